// >>> design/ibus_pkg.sv
package ibus_pkg;

    // Instrument bus addresses, full 8-bit match
    localparam logic [7:0] OFS_RES      = 8'h3F;
    localparam logic [7:0] OFS_ATTEN    = 8'h4F;
    localparam logic [7:0] OFS_VOFFSET  = 8'h78;
    localparam logic [7:0] OFS_MODE     = 8'h79;
    localparam logic [7:0] OFS_ST_IN    = 8'h7A;
    localparam logic [7:0] OFS_ST_CTL   = 8'h7B;
    localparam logic [7:0] OFS_VPROC    = 8'h7C;
    localparam logic [7:0] OFS_ST_OUT   = 8'hFA;

    // Field positions
    localparam int STEER_BIT    = 7;
    localparam int PSTRETCH_BIT = 7;
    localparam int IDOFS_BIT    = 6;
    localparam int DMODE_LSB    = 4;
    localparam int RUN_BIT      = 7;
    localparam int CURSOR_LSB   = 5;
    localparam int MAXHOLD_BIT  = 4;
    localparam int VDIFF_BIT    = 3;
    localparam int VIEWB_BIT    = 2;
    localparam int VIEWA_BIT    = 1;
    localparam int SAVEA_BIT    = 0;
    localparam int BLEVEL_BIT   = 0;
    localparam int CLIP_BIT     = 7;
    localparam int ASWITCH_BIT  = 3;

    // Values after reset
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [2:0] IDX_RESET  = 3'h0;

    // Display storage: one byte per horizontal point
    localparam int           PTR_W      = 9;
    localparam logic [8:0]   LAST_POINT = 9'h1FF;

    typedef struct packed {
        logic       dv_prev;
        logic [7:0] res_bw;
        logic [7:0] res_gain;
        logic [7:0] atten;
        logic [7:0] voffset;
        logic [7:0] mode;
        logic [7:0] vproc;
        logic [7:0] st_ctl;
        logic [2:0] rbw_sel;
        logic       rbw_ok;
        logic [2:0] gain_step;
        logic       gain_ok;
        logic [2:0] clamp_sel;
        logic       clamp_ok;
        logic [2:0] vfilt_sel;
        logic       vfilt_ok;
        logic [2:0] atten_step;
        logic       atten_ok;
    } regs_type;

    typedef struct packed {
        logic [8:0] wr_ptr;
        logic [8:0] rd_ptr;
        logic [7:0] rd_data;
    } store_type;

endpackage

// >>> design/code_decode.sv
`timescale 1ns/1ps
// Turns raw data bytes into compact selection indices; ok low marks an unlisted code
module code_decode
    import ibus_pkg::*;
(
    input  wire logic [7:0] data,
    output logic      [2:0] rbw_sel,
    output logic            rbw_ok,
    output logic      [2:0] gain_step,
    output logic            gain_ok,
    output logic      [2:0] clamp_sel,
    output logic            clamp_ok,
    output logic      [2:0] vfilt_sel,
    output logic            vfilt_ok,
    output logic      [2:0] atten_step,
    output logic            atten_ok
);

    // Bandwidth: 0=1 MHz 1=100 kHz 2=10 kHz 3=100 Hz 4=30 Hz; 001 taken as 1 MHz
    always_comb begin
        rbw_ok = 1'b1;
        case (data[2:0])
            3'h1:    rbw_sel = 3'h0; // R3
            3'h2:    rbw_sel = 3'h1;
            3'h3:    rbw_sel = 3'h2;
            3'h5:    rbw_sel = 3'h3;
            3'h6:    rbw_sel = 3'h4;
            default: begin
                rbw_sel = 3'h0;
                rbw_ok  = 1'b0;
            end
        endcase
    end

    // Added gain in 10 dB steps; leveling normal only with bits 6:3 clear
    always_comb begin
        gain_ok = 1'b1;
        case (data[2:0])
            3'h0:    gain_step = 3'h0; // R4
            3'h1:    gain_step = 3'h1;
            3'h4:    gain_step = 3'h2;
            3'h5:    gain_step = 3'h3;
            3'h7:    gain_step = 3'h4;
            default: begin
                gain_step = 3'h0;
                gain_ok   = 1'b0;
            end
        endcase
    end

    // Clamp from bits 5,6,7: 0 none, 1 upper five, 2 lower, 3 lower five
    always_comb begin
        clamp_ok = 1'b1;
        case ({data[5], data[6], data[7]})
            3'h6:    clamp_sel = 3'h0; // R7
            3'h4:    clamp_sel = 3'h1;
            3'h7:    clamp_sel = 3'h2;
            3'h2:    clamp_sel = 3'h3;
            default: begin
                clamp_sel = 3'h0;
                clamp_ok  = 1'b0;
            end
        endcase
    end

    // Video filter: 0 off, 1 30k, 2 3k, 3 300, 4 30, 5 3, 6 0.3 Hz
    always_comb begin
        vfilt_ok = 1'b1;
        case (data[4:1])
            4'h0:    vfilt_sel = 3'h0; // R8
            4'h1:    vfilt_sel = 3'h1;
            4'h9:    vfilt_sel = 3'h2;
            4'hD:    vfilt_sel = 3'h3;
            4'h3:    vfilt_sel = 3'h4;
            4'hB:    vfilt_sel = 3'h5;
            4'hF:    vfilt_sel = 3'h6;
            default: begin
                vfilt_sel = 3'h0;
                vfilt_ok  = 1'b0;
            end
        endcase
    end

    // Attenuation in 10 dB steps from bits 6,2,0; 111 taken as 0 dB, 60 dB unreachable
    always_comb begin
        atten_ok = 1'b1;
        case ({data[6], data[2], data[0]})
            3'h7:    atten_step = 3'h0; // R15
            3'h6:    atten_step = 3'h1;
            3'h3:    atten_step = 3'h2;
            3'h5:    atten_step = 3'h3;
            3'h4:    atten_step = 3'h4;
            3'h1:    atten_step = 3'h5;
            default: begin
                atten_step = 3'h0;
                atten_ok   = 1'b0;
            end
        endcase
    end

endmodule // code_decode

// >>> design/display_store.sv
`timescale 1ns/1ps
// Display storage with auto-advancing input and output point counters
module display_store
    import ibus_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       wr_take,
    input  wire logic       restart,
    input  wire logic       rd_load,
    input  wire logic       rd_adv,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] rd_data
);

    logic [7:0] mem [0:LAST_POINT];
    store_type  s_r;
    store_type  s_nxt;

    // Counters wrap after the last point so a full trace can be streamed repeatedly
    always_comb begin
        s_nxt = s_r;
        if (restart) begin
            s_nxt.wr_ptr = '0; // R10
            s_nxt.rd_ptr = '0; // R11
        end else begin
            if (wr_take) begin
                s_nxt.wr_ptr = (s_r.wr_ptr == LAST_POINT) ? '0 : s_r.wr_ptr + 9'h001; // R9 R20
            end
            if (rd_adv) begin
                s_nxt.rd_ptr = (s_r.rd_ptr == LAST_POINT) ? '0 : s_r.rd_ptr + 9'h001; // R11 R20
            end
        end
        if (rd_load) begin
            s_nxt.rd_data = mem[s_r.rd_ptr];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '{wr_ptr: '0, rd_ptr: '0, rd_data: REG_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Array has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_take) begin
            mem[s_r.wr_ptr] <= wr_data; // R9
        end
    end

    assign rd_data = s_r.rd_data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_wr_advance: assert property (wr_take && !restart && s_r.wr_ptr != LAST_POINT
        |=> s_r.wr_ptr == $past(s_r.wr_ptr) + 9'h001) // R9
        else $error("input point counter did not advance");
    a_restart_left: assert property (restart |=> s_r.wr_ptr == '0 && s_r.rd_ptr == '0) // R10
        else $error("restart left a counter off the leftmost point");
    a_ptr_wrap: assert property (rd_adv && !restart && s_r.rd_ptr == LAST_POINT |=> s_r.rd_ptr == '0) // R20
        else $error("output counter did not wrap");

endmodule // display_store

// >>> design/ibus_regs.sv
`timescale 1ns/1ps
// What this block does; R16, R17 and R18 are the host's duties
// (R1) Write 3F with bit 7 set loads bandwidth bits 2:0, gain kept.
// (R2) Write 3F with bit 7 clear loads gain bits 6:0, bandwidth kept.
// (R3) Bandwidth code decodes to 1M, 100k, 10k, 100, 30 Hz.
// (R4) Gain byte: bits 6:3 zero is normal leveling; bits 2:0 pick gain.
// (R5) Register 78 holds an 8-bit video offset, quarter dB per count.
// (R6) Register 79: stretcher, identify offset, display mode, log scale factor.
// (R7) Register 7C bits 5,6,7 select out-of-band clamping.
// (R8) Register 7C bits 4:1 select video filter; bit 0 base-line leveling.
// (R9) Each write to 7A stores at input counter, which then advances.
// (R10) Any write to 7B clears the input counter.
// (R11) Reads of FA stream stored values left to right; 7B restarts.
// (R12) Register 7B: bit 7 run/halt acquisition, bits 6:5 cursor source.
// (R13) Register 7B bits 4:0 enable peak hold, difference, B, A, freeze A.
// (R14) Register 4F bit 7 switches the baseline clipper.
// (R15) Register 4F bits 6,2,0 select RF attenuation.
// (R16) Host keeps 4F bits 5:4 zero and holds bit 3 low 100 ms.
// (R17) Host writes upper nibble as first hex digit, lower as second.
// (R18) Address changes only with strobe low, data only with strobe high.
// (R19) Each register is fully address decoded and holds until rewritten.
// (R20) Storage counters wrap after the last display point.
module ibus_regs
    import ibus_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] DATA_IN,
    input  wire logic       DATA_VALID,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE_N,
    output logic      [2:0] RBW_CODE,
    output logic      [2:0] RBW_SEL,
    output logic            RBW_VALID,
    output logic      [3:0] LEVELING,
    output logic            LEVEL_NORMAL,
    output logic      [2:0] GAIN_STEP,
    output logic            GAIN_VALID,
    output logic      [7:0] VIDEO_OFFSET,
    output logic            PULSE_STRETCH,
    output logic            IDENT_OFFSET,
    output logic      [1:0] DISPLAY_MODE,
    output logic      [3:0] LOG_SCALE,
    output logic      [2:0] CLAMP_SEL,
    output logic            CLAMP_VALID,
    output logic      [2:0] VFILT_SEL,
    output logic            VFILT_VALID,
    output logic            BASELINE_LEVEL,
    output logic            ACQ_RUN,
    output logic      [1:0] LEVEL_CURSOR_SOURCE,
    output logic            PEAK_HOLD,
    output logic            VIEW_DIFF,
    output logic            VIEW_B,
    output logic            VIEW_A,
    output logic            FREEZE_A,
    output logic            CLIPPER_ON,
    output logic            ATTEN_SWITCH,
    output logic      [2:0] ATTEN_STEP,
    output logic            ATTEN_VALID
);

    regs_type   r_r;
    regs_type   r_nxt;
    logic       wr_take;
    logic       fall;
    logic       rd_sel;
    logic [2:0] d_rbw;
    logic       d_rbw_ok;
    logic [2:0] d_gain;
    logic       d_gain_ok;
    logic [2:0] d_clamp;
    logic       d_clamp_ok;
    logic [2:0] d_vfilt;
    logic       d_vfilt_ok;
    logic [2:0] d_atten;
    logic       d_atten_ok;

    // A transfer completes on the strobe's rising edge: address and data are both settled then
    assign wr_take = DATA_VALID && !r_r.dv_prev && !ADDR[7]; // R18
    assign fall    = !DATA_VALID && r_r.dv_prev;
    assign rd_sel  = ADDR == OFS_ST_OUT;

    code_decode u_decode (
        .data       (DATA_IN),
        .rbw_sel    (d_rbw),
        .rbw_ok     (d_rbw_ok),
        .gain_step  (d_gain),
        .gain_ok    (d_gain_ok),
        .clamp_sel  (d_clamp),
        .clamp_ok   (d_clamp_ok),
        .vfilt_sel  (d_vfilt),
        .vfilt_ok   (d_vfilt_ok),
        .atten_step (d_atten),
        .atten_ok   (d_atten_ok)
    );

    // Register writes; decoded indices are captured with the byte so outputs come from flops
    always_comb begin
        r_nxt         = r_r;
        r_nxt.dv_prev = DATA_VALID;
        if (wr_take) begin
            unique case (ADDR) // R19
                OFS_RES: begin
                    if (DATA_IN[STEER_BIT]) begin
                        r_nxt.res_bw  = DATA_IN; // R1
                        r_nxt.rbw_sel = d_rbw; // R3
                        r_nxt.rbw_ok  = d_rbw_ok;
                    end else begin
                        r_nxt.res_gain  = DATA_IN; // R2
                        r_nxt.gain_step = d_gain; // R4
                        r_nxt.gain_ok   = d_gain_ok;
                    end
                end
                OFS_VOFFSET: r_nxt.voffset = DATA_IN; // R5
                OFS_MODE:    r_nxt.mode    = DATA_IN; // R6
                OFS_VPROC: begin
                    r_nxt.vproc     = DATA_IN;
                    r_nxt.clamp_sel = d_clamp; // R7
                    r_nxt.clamp_ok  = d_clamp_ok;
                    r_nxt.vfilt_sel = d_vfilt; // R8
                    r_nxt.vfilt_ok  = d_vfilt_ok;
                end
                OFS_ST_CTL:  r_nxt.st_ctl = DATA_IN; // R12 R13
                OFS_ATTEN: begin
                    // Bits 5:4 and the switch timing are the host's duty; stored as given
                    r_nxt.atten      = DATA_IN; // R14 R16
                    r_nxt.atten_step = d_atten; // R15
                    r_nxt.atten_ok   = d_atten_ok;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            r_r <= '{dv_prev: 1'b1, res_bw: REG_RESET, res_gain: REG_RESET, atten: REG_RESET,
                     voffset: REG_RESET, mode: REG_RESET, vproc: REG_RESET, st_ctl: REG_RESET,
                     rbw_sel: IDX_RESET, rbw_ok: 1'b0, gain_step: IDX_RESET, gain_ok: 1'b1,
                     clamp_sel: IDX_RESET, clamp_ok: 1'b0, vfilt_sel: IDX_RESET, vfilt_ok: 1'b1,
                     atten_step: IDX_RESET, atten_ok: 1'b0};
        end else begin
            r_r <= r_nxt;
        end
    end

    // Storage: a write to the control address also rewinds both counters
    display_store u_store (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .wr_take (wr_take && ADDR == OFS_ST_IN), // R9
        .restart (wr_take && ADDR == OFS_ST_CTL), // R10 R11
        .rd_load (fall && rd_sel),
        .rd_adv  (DATA_VALID && !r_r.dv_prev && rd_sel), // R11
        .wr_data (DATA_IN),
        .rd_data (DATA_OUT)
    );

    // Drive only from the second low cycle, once the fetched byte sits in its flop
    assign DATA_OE_N = !(!DATA_VALID && !r_r.dv_prev && rd_sel); // R18

    // Output fields
    assign RBW_CODE            = r_r.res_bw[2:0];
    assign RBW_SEL             = r_r.rbw_sel;
    assign RBW_VALID           = r_r.rbw_ok;
    assign LEVELING            = r_r.res_gain[6:3];
    assign LEVEL_NORMAL        = r_r.res_gain[6:3] == 4'h0; // R4
    assign GAIN_STEP           = r_r.gain_step;
    assign GAIN_VALID          = r_r.gain_ok;
    assign VIDEO_OFFSET        = r_r.voffset;
    assign PULSE_STRETCH       = r_r.mode[PSTRETCH_BIT]; // R6
    assign IDENT_OFFSET        = r_r.mode[IDOFS_BIT];
    assign DISPLAY_MODE        = r_r.mode[DMODE_LSB +: 2];
    assign LOG_SCALE           = r_r.mode[3:0];
    assign CLAMP_SEL           = r_r.clamp_sel;
    assign CLAMP_VALID         = r_r.clamp_ok;
    assign VFILT_SEL           = r_r.vfilt_sel;
    assign VFILT_VALID         = r_r.vfilt_ok;
    assign BASELINE_LEVEL      = r_r.vproc[BLEVEL_BIT]; // R8
    assign ACQ_RUN             = r_r.st_ctl[RUN_BIT]; // R12
    assign LEVEL_CURSOR_SOURCE = r_r.st_ctl[CURSOR_LSB +: 2];
    assign PEAK_HOLD           = r_r.st_ctl[MAXHOLD_BIT]; // R13
    assign VIEW_DIFF           = r_r.st_ctl[VDIFF_BIT];
    assign VIEW_B              = r_r.st_ctl[VIEWB_BIT];
    assign VIEW_A              = r_r.st_ctl[VIEWA_BIT];
    assign FREEZE_A            = r_r.st_ctl[SAVEA_BIT];
    assign CLIPPER_ON          = r_r.atten[CLIP_BIT]; // R14
    assign ATTEN_SWITCH        = r_r.atten[ASWITCH_BIT];
    assign ATTEN_STEP          = r_r.atten_step;
    assign ATTEN_VALID         = r_r.atten_ok;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_write(logic [7:0] a);
        DATA_VALID && !r_r.dv_prev && ADDR == a;
    endsequence

    sequence s_read_start;
        !DATA_VALID && r_r.dv_prev && rd_sel;
    endsequence

    a_bw_steer: assert property (s_write(OFS_RES) and DATA_IN[7]
        |=> RBW_CODE == $past(DATA_IN[2:0]) && $stable(r_r.res_gain)) // R1
        else $error("bandwidth write wrong or disturbed gain");
    a_gain_steer: assert property (s_write(OFS_RES) and !DATA_IN[7]
        |=> LEVELING == $past(DATA_IN[6:3]) && $stable(r_r.res_bw)) // R2
        else $error("gain write wrong or disturbed bandwidth");
    a_rbw_decode: assert property (s_write(OFS_RES) and DATA_IN[7] && DATA_IN[2:0] == 3'h6
        |=> RBW_SEL == 3'h4 && RBW_VALID) // R3
        else $error("30 Hz code not decoded");
    a_gain_decode: assert property (s_write(OFS_RES) and DATA_IN == 8'h07 |=> GAIN_STEP == 3'h4 && LEVEL_NORMAL) // R4
        else $error("40 dB gain code not decoded");
    a_offset_load: assert property (s_write(OFS_VOFFSET) |=> VIDEO_OFFSET == $past(DATA_IN)) // R5
        else $error("video offset not loaded");
    a_mode_fields: assert property (s_write(OFS_MODE)
        |=> PULSE_STRETCH == $past(DATA_IN[7]) && DISPLAY_MODE == $past(DATA_IN[5:4])) // R6
        else $error("mode fields not loaded");
    a_clamp_decode: assert property (s_write(OFS_VPROC) and DATA_IN[7:5] == 3'h3 |=> CLAMP_SEL == 3'h0 && CLAMP_VALID) // R7
        else $error("no-clamp code not decoded");
    a_filter_decode: assert property (s_write(OFS_VPROC) and DATA_IN[4:1] == 4'hF
        |=> VFILT_SEL == 3'h6 && BASELINE_LEVEL == $past(DATA_IN[0])) // R8
        else $error("filter or leveling not decoded");
    a_store_ctl: assert property (s_write(OFS_ST_CTL)
        |=> ACQ_RUN == $past(DATA_IN[7]) && FREEZE_A == $past(DATA_IN[0])) // R12 R13
        else $error("storage control not loaded");
    a_clip_atten: assert property (s_write(OFS_ATTEN) and DATA_IN[7] && {DATA_IN[6], DATA_IN[2], DATA_IN[0]} == 3'h1
        |=> CLIPPER_ON && ATTEN_STEP == 3'h5) // R14 R15
        else $error("clipper or 50 dB code wrong");
    a_hold_value: assert property (!wr_take |=> $stable(r_r.voffset) && $stable(r_r.atten)) // R19
        else $error("register changed without a write");
    a_read_drive: assert property (s_read_start ##1 (!DATA_VALID && rd_sel) |-> !DATA_OE_N) // R11 R18
        else $error("storage read not driven");
    a_no_drive_high: assert property (DATA_VALID |-> DATA_OE_N) // R18
        else $error("data driven while strobe high");

endmodule // ibus_regs

// >>> bench/host_model.sv
`timescale 1ns/1ps
// Host side of the instrument bus; every change lands on a falling clock edge
module host_model (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic      [7:0] data_in,
    output logic            data_valid,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe_n
);
    // Idle with the strobe high, so reset release sees no false fall
    initial begin
        addr       = 8'h00;
        data_in    = 8'h00;
        data_valid = 1'b1;
    end

    // Data moves only with the strobe high, address only with it low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        data_in    = {d[7:4], d[3:0]};
        @(negedge clk);
        data_valid = 1'b0;
        addr       = a;
        @(negedge clk);
        data_valid = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // Output is loaded and driven from the first rising edge after the fall, and sampled two falling edges later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe_n);
        @(negedge clk);
        data_valid = 1'b0;
        addr       = a;
        repeat (2) @(negedge clk);
        d          = data_out;
        oe_n       = data_oe_n;
        data_valid = 1'b1;
        // Extra idle edge lets the read counter settle before the next fall
        repeat (2) @(negedge clk);
    endtask
endmodule // host_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
// Register writes, decode tables and the display storage stream
module tb_top
    import ibus_pkg::*;
;
    logic       CORE_CLK = 1'b0;
    logic       RST_N    = 1'b0;
    logic [7:0] ADDR, DATA_IN, DATA_OUT, VIDEO_OFFSET;
    logic [3:0] LEVELING, LOG_SCALE;
    logic [2:0] RBW_CODE, RBW_SEL, GAIN_STEP, CLAMP_SEL, VFILT_SEL, ATTEN_STEP;
    logic [1:0] DISPLAY_MODE, LEVEL_CURSOR_SOURCE;
    logic       DATA_VALID, DATA_OE_N, RBW_VALID, LEVEL_NORMAL, GAIN_VALID, PULSE_STRETCH;
    logic       IDENT_OFFSET, CLAMP_VALID, VFILT_VALID, BASELINE_LEVEL, ACQ_RUN, PEAK_HOLD;
    logic       VIEW_DIFF, VIEW_B, VIEW_A, FREEZE_A, CLIPPER_ON, ATTEN_SWITCH, ATTEN_VALID;
    int         fail_count = 0;
    int         checked    = 0;
    int         cycles     = 0;

    // Codes listed in order of their selection index
    localparam logic [2:0] RBW_CODES [5]   = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    localparam logic [2:0] GAIN_CODES [5]  = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h7};
    localparam logic [2:0] CLAMP_CODES [4] = '{3'h6, 3'h4, 3'h7, 3'h2};
    localparam logic [3:0] VF_CODES [7]    = '{4'h0, 4'h1, 4'h9, 4'hD, 4'h3, 4'hB, 4'hF};
    localparam logic [2:0] ATT_CODES [6]   = '{3'h7, 3'h6, 3'h3, 3'h5, 3'h4, 3'h1};
    localparam logic [7:0] PAT [4]         = '{8'hA5, 8'h5C, 8'hE0, 8'h03};

    always #12.5 CORE_CLK = ~CORE_CLK;

    ibus_regs u_ibus_regs (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .DATA_IN(DATA_IN), .DATA_VALID(DATA_VALID),
        .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N), .RBW_CODE(RBW_CODE), .RBW_SEL(RBW_SEL),
        .RBW_VALID(RBW_VALID), .LEVELING(LEVELING), .LEVEL_NORMAL(LEVEL_NORMAL), .GAIN_STEP(GAIN_STEP),
        .GAIN_VALID(GAIN_VALID), .VIDEO_OFFSET(VIDEO_OFFSET), .PULSE_STRETCH(PULSE_STRETCH),
        .IDENT_OFFSET(IDENT_OFFSET), .DISPLAY_MODE(DISPLAY_MODE), .LOG_SCALE(LOG_SCALE),
        .CLAMP_SEL(CLAMP_SEL), .CLAMP_VALID(CLAMP_VALID), .VFILT_SEL(VFILT_SEL), .VFILT_VALID(VFILT_VALID),
        .BASELINE_LEVEL(BASELINE_LEVEL), .ACQ_RUN(ACQ_RUN), .LEVEL_CURSOR_SOURCE(LEVEL_CURSOR_SOURCE),
        .PEAK_HOLD(PEAK_HOLD), .VIEW_DIFF(VIEW_DIFF), .VIEW_B(VIEW_B), .VIEW_A(VIEW_A),
        .FREEZE_A(FREEZE_A), .CLIPPER_ON(CLIPPER_ON), .ATTEN_SWITCH(ATTEN_SWITCH),
        .ATTEN_STEP(ATTEN_STEP), .ATTEN_VALID(ATTEN_VALID)
    );

    host_model u_host_model (
        .clk(CORE_CLK), .addr(ADDR), .data_in(DATA_IN), .data_valid(DATA_VALID),
        .data_out(DATA_OUT), .data_oe_n(DATA_OE_N)
    );

    // Case equality, so an unknown never passes
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Points 0 and 1 are overwritten once the input counter wraps
    function automatic logic [7:0] point_val(input int p);
        return (p < 2) ? 8'hC0 + 8'(p) : 8'(p);
    endfunction

    // Ceiling far above the roughly 5400 cycles the sequence needs
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        logic [7:0] rd_val;
        logic       oe;
        logic [7:0] b;
        logic [2:0] c;
        repeat (20) @(negedge CORE_CLK);
        RST_N = 1'b1;
        chk(VIDEO_OFFSET, 8'h00, "offset reset");
        chk({6'h00, RBW_VALID, DATA_OE_N}, 8'h01, "reset flags");
        // Gain first, so the bandwidth writes can be seen to leave it alone
        u_host_model.wr(OFS_RES, 8'h7D);
        chk({3'h0, LEVELING, LEVEL_NORMAL}, 8'h1E, "leveling");
        for (int i = 0; i < 5; i++) begin
            u_host_model.wr(OFS_RES, {5'h1A, RBW_CODES[i]});
            chk({5'h00, RBW_CODE}, {5'h00, RBW_CODES[i]}, "rbw code");
            chk({4'h0, RBW_VALID, RBW_SEL}, 8'h08 + 8'(i), "rbw sel");
            chk({5'h00, GAIN_STEP}, 8'h03, "gain kept");
        end
        for (int i = 0; i < 5; i++) begin
            u_host_model.wr(OFS_RES, {5'h00, GAIN_CODES[i]});
            chk({3'h0, LEVEL_NORMAL, GAIN_VALID, GAIN_STEP}, 8'h18 + 8'(i), "gain");
            chk({5'h00, RBW_SEL}, 8'h04, "rbw kept");
        end
        u_host_model.wr(OFS_RES, 8'h02);
        chk({6'h00, GAIN_VALID, LEVEL_NORMAL}, 8'h01, "gain refused");
        u_host_model.wr(OFS_RES, 8'h80);
        chk({7'h00, RBW_VALID}, 8'h00, "rbw refused");
        // Unmapped address must not disturb a neighbour
        u_host_model.wr(OFS_VOFFSET, 8'hFF);
        u_host_model.wr(8'h77, 8'h12);
        chk(VIDEO_OFFSET, 8'hFF, "offset");
        for (int k = 0; k < 4; k++) begin
            u_host_model.wr(OFS_MODE, PAT[k]);
            u_host_model.wr(OFS_ST_CTL, PAT[k]);
            chk({PULSE_STRETCH, IDENT_OFFSET, DISPLAY_MODE, LOG_SCALE}, PAT[k], "mode");
            chk({ACQ_RUN, LEVEL_CURSOR_SOURCE, PEAK_HOLD, VIEW_DIFF, VIEW_B, VIEW_A, FREEZE_A},
                PAT[k], "storage ctl");
        end
        for (int i = 0; i < 7; i++) begin
            c = CLAMP_CODES[i % 4];
            b = {c[0], c[1], c[2], VF_CODES[i], 1'(i % 2)};
            u_host_model.wr(OFS_VPROC, b);
            chk({4'h0, CLAMP_VALID, CLAMP_SEL}, 8'h08 + 8'(i % 4), "clamp");
            chk({3'h0, BASELINE_LEVEL, VFILT_VALID, VFILT_SEL}, {3'h0, 1'(i % 2), 1'b1, 3'(i)}, "filter");
        end
        u_host_model.wr(OFS_VPROC, 8'h04);
        chk({6'h00, CLAMP_VALID, VFILT_VALID}, 8'h00, "vproc refused");
        // Bits 5:4 stay zero in every host write; bit 3 drops once and is never raised again
        for (int i = 0; i < 6; i++) begin
            c = ATT_CODES[i];
            b = {1'(i % 2), c[2], 2'b00, 1'(i < 3), c[1], 1'b0, c[0]};
            u_host_model.wr(OFS_ATTEN, b);
            chk({CLIPPER_ON, ATTEN_SWITCH, ATTEN_VALID, 2'b00, ATTEN_STEP},
                {1'(i % 2), 1'(i < 3), 3'b100, 3'(i)}, "atten");
        end
        u_host_model.wr(OFS_ATTEN, 8'h00);
        chk({6'h00, CLIPPER_ON, ATTEN_VALID}, 8'h00, "atten refused");
        // Stray writes move the input counter before it is cleared
        for (int i = 0; i < 3; i++) begin
            u_host_model.wr(OFS_ST_IN, 8'hEE);
        end
        u_host_model.wr(OFS_ST_CTL, 8'h80);
        for (int i = 0; i < 514; i++) begin
            u_host_model.wr(OFS_ST_IN, (i < 512) ? 8'(i) : point_val(i - 512));
        end
        u_host_model.rd(OFS_ST_OUT, rd_val, oe);
        chk(rd_val, 8'hC0, "first point");
        u_host_model.rd(OFS_ST_OUT, rd_val, oe);
        u_host_model.wr(OFS_ST_CTL, 8'h80);
        for (int j = 0; j < 514; j++) begin
            u_host_model.rd(OFS_ST_OUT, rd_val, oe);
            chk(rd_val, point_val(j % 512), "stored point");
            chk({7'h00, oe}, 8'h00, "read drive");
        end
        chk({7'h00, DATA_OE_N}, 8'h01, "released");
        u_host_model.rd(8'hF4, rd_val, oe);
        chk({7'h00, oe}, 8'h01, "other read");
        close_out();
    end
endmodule // tb_top
